// file: inc/sram_port_pkg.sv
`default_nettype none
package sram_port_pkg;
	// Array geometry: four byte lanes, each eight data bits plus parity
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int DATA_W = LANES * BYTE_W;
	localparam int MEM_WORDS = 1 << ADDR_W;
	localparam int BUF_DEPTH = 2;
	localparam int BURST_W = 2;

	// Reset and constant values
	localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic MODE_LINEAR_RST = 1'b0;
	localparam logic [LANES-1:0] ALL_LANES = 4'hF;
	localparam logic [LANES-1:0] NO_LANES = 4'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_SLEEP = 2'b10
	} state_e;

	// Raw pin levels as they cross into the clock domain
	typedef struct packed {
		logic cs_low_a;
		logic cs_high;
		logic cs_low_b;
		logic proc_addr_strobe_n_n;
		logic ctrl_addr_strobe_n_n;
		logic adv_n;
		logic bwe_n;
		logic [LANES-1:0] bsel_n;
		logic gw_n;
		logic oe_n;
		logic sleep;
		logic order;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0] par;
	} pins_s;

	// One pending write on its way to the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0] par;
		logic [LANES-1:0] lanes;
	} wr_entry_s;
endpackage
`default_nettype wire

// file: rtl/word_buffer.sv
`default_nettype none
module word_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(DEPTH);

	logic [WIDTH-1:0] slot [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] fill;
	logic [PTR_W-1:0] next_wr_ptr;
	logic [PTR_W-1:0] next_rd_ptr;
	logic [PTR_W:0] next_fill;
	logic push;
	logic pop;

	// Honest flags straight from the fill count
	assign in_ready = (fill != FULL);
	assign out_valid = (fill != '0);
	assign out_data = slot[rd_ptr];

	// Pointer and fill bookkeeping
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_fill = fill;
		if (push) begin
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_fill = fill + 1'b1;
		end else if (pop && !push) begin
			next_fill = fill - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
		end
	end

	// Storage needs no reset; the fill count guards it
	always_ff @(posedge core_clk) begin
		if (push) begin
			slot[wr_ptr] <= in_data;
		end
	end
endmodule // word_buffer
`default_nettype wire

// file: rtl/sync_burst_sram_port.sv
`default_nettype none
module sync_burst_sram_port #(
	parameter bit HAS_LOW_B = 1'b1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic chip_select_low_a,
	input wire logic chip_select_high,
	input wire logic chip_select_low_b,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic byte_write_enable_n,
	input wire logic [sram_port_pkg::LANES-1:0] byte_select_n,
	input wire logic global_write_n,
	input wire logic output_enable_n,
	input wire logic sleep_req,
	input wire logic burst_order,
	input wire logic [sram_port_pkg::ADDR_W-1:0] addr,
	input wire logic [sram_port_pkg::DATA_W-1:0] data_io_in,
	output wire logic [sram_port_pkg::DATA_W-1:0] data_io_out,
	output logic data_io_oe_n,
	input wire logic [sram_port_pkg::LANES-1:0] parity_io_in,
	output wire logic [sram_port_pkg::LANES-1:0] parity_io_out,
	output logic parity_io_oe_n,
	output logic write_ready
);
	localparam int AW = sram_port_pkg::ADDR_W;
	localparam int BW = sram_port_pkg::BURST_W;

	sram_port_pkg::pins_s pin_raw;
	sram_port_pkg::pins_s pin_meta;
	sram_port_pkg::pins_s s;
	sram_port_pkg::state_e state;
	sram_port_pkg::state_e next_state;
	logic [AW-1:0] addr_reg;
	logic [AW-1:0] next_addr_reg;
	logic [BW-1:0] start;
	logic [BW-1:0] next_start;
	logic [BW-1:0] cnt;
	logic [BW-1:0] next_cnt;
	logic first_read;
	logic next_first;
	logic wphase;
	logic next_wphase;
	logic mode_pending;
	logic next_mode_pending;
	logic mode_linear;
	logic next_mode_linear;
	logic strobe_p;
	logic start_acc;
	logic sel_ok;
	logic [sram_port_pkg::LANES-1:0] wr_lanes;
	logic [AW-1:0] cur_addr;
	logic [AW-1:0] rd_addr;
	logic push;
	logic drive;
	sram_port_pkg::wr_entry_s push_entry;
	sram_port_pkg::wr_entry_s drain_entry;
	logic drain_valid;
	logic drain_fire;

	// Burst sequence: linear adds, interleaved XORs the count
	function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] st,
			input logic [BW-1:0] c, input logic lin);
		burst_low = lin ? BW'(st + c) : (st ^ c);
	endfunction

	// Every pin is foreign to core_clk, so two flops before use
	assign pin_raw = '{
		cs_low_a: chip_select_low_a,
		cs_high: chip_select_high,
		cs_low_b: chip_select_low_b,
		proc_addr_strobe_n_n: proc_addr_strobe_n,
		ctrl_addr_strobe_n_n: ctrl_addr_strobe_n,
		adv_n: burst_advance_n,
		bwe_n: byte_write_enable_n,
		bsel_n: byte_select_n,
		gw_n: global_write_n,
		oe_n: output_enable_n,
		sleep: sleep_req,
		order: burst_order,
		addr: addr,
		data: data_io_in,
		par: parity_io_in
	};

	// Second stage also serves as the input register
	always_ff @(posedge core_clk) begin
		pin_meta <= pin_raw;
		s <= pin_meta;
	end

	// Strobe qualification and select decode
	always_comb begin
		strobe_p = !s.proc_addr_strobe_n_n && !s.cs_low_a;
		start_acc = strobe_p || !s.ctrl_addr_strobe_n_n;
		sel_ok = !s.cs_low_a && s.cs_high
			&& (!HAS_LOW_B || !s.cs_low_b);
		if (!s.gw_n) begin
			wr_lanes = sram_port_pkg::ALL_LANES;
		end else if (!s.bwe_n) begin
			wr_lanes = ~s.bsel_n;
		end else begin
			wr_lanes = sram_port_pkg::NO_LANES;
		end
		cur_addr = {addr_reg[AW-1:BW], burst_low(start, cnt, mode_linear)};
		rd_addr = {next_addr_reg[AW-1:BW],
			burst_low(next_start, next_cnt, mode_linear)};
	end

	// Write entry: a fresh address on a strobe cycle, else the burst one
	always_comb begin
		push_entry.addr = start_acc ? s.addr : cur_addr;
		push_entry.data = s.data;
		push_entry.par = s.par;
		push_entry.lanes = wr_lanes;
	end

	// Access sequencer
	always_comb begin
		next_state = state;
		next_addr_reg = addr_reg;
		next_start = start;
		next_cnt = cnt;
		next_first = 1'b0;
		next_wphase = 1'b0;
		push = 1'b0;
		case (state)
			sram_port_pkg::ST_SLEEP: begin
				if (!s.sleep) begin
					next_state = sram_port_pkg::ST_IDLE;
				end
			end
			sram_port_pkg::ST_IDLE, sram_port_pkg::ST_ACTIVE: begin
				if (s.sleep) begin
					next_state = sram_port_pkg::ST_SLEEP;
				end else if (start_acc) begin
					if (sel_ok) begin
						next_state = sram_port_pkg::ST_ACTIVE;
						next_addr_reg = s.addr;
						next_start = s.addr[BW-1:0];
						next_cnt = sram_port_pkg::BURST_CNT_RST;
						// Processor strobe never writes first cycle
						if (!strobe_p
								&& wr_lanes != sram_port_pkg::NO_LANES) begin
							push = 1'b1;
							next_wphase = 1'b1;
						end else begin
							next_first = (state == sram_port_pkg::ST_IDLE);
						end
					end else begin
						next_state = sram_port_pkg::ST_IDLE;
					end
				end else if (state == sram_port_pkg::ST_ACTIVE) begin
					// Selects are not looked at here
					if (wr_lanes != sram_port_pkg::NO_LANES) begin
						push = 1'b1;
						next_wphase = 1'b1;
					end
					if (!s.adv_n) begin
						next_cnt = BW'(cnt + 1'b1);
					end
				end
			end
			default: begin
				next_state = sram_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= sram_port_pkg::ST_IDLE;
			addr_reg <= sram_port_pkg::ADDR_RST;
			start <= sram_port_pkg::BURST_CNT_RST;
			cnt <= sram_port_pkg::BURST_CNT_RST;
			first_read <= 1'b0;
			wphase <= 1'b0;
		end else begin
			state <= next_state;
			addr_reg <= next_addr_reg;
			start <= next_start;
			cnt <= next_cnt;
			first_read <= next_first;
			wphase <= next_wphase;
		end
	end

	// Strap caught once after reset release; later changes ignored
	always_comb begin
		next_mode_pending = 1'b0;
		next_mode_linear = mode_pending ? !s.order : mode_linear;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_pending <= 1'b1;
			mode_linear <= sram_port_pkg::MODE_LINEAR_RST;
		end else begin
			mode_pending <= next_mode_pending;
			mode_linear <= next_mode_linear;
		end
	end

	// Writes park here; the drain stalls while asleep
	assign drain_fire = drain_valid && state != sram_port_pkg::ST_SLEEP;

	word_buffer #(
		.WIDTH($bits(sram_port_pkg::wr_entry_s)),
		.DEPTH(sram_port_pkg::BUF_DEPTH)
	) u_wr_buf (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_ready(write_ready),
		.in_data(push_entry),
		.out_valid(drain_valid),
		.out_ready(state != sram_port_pkg::ST_SLEEP),
		.out_data(drain_entry)
	);

	// One array per lane; a same-cycle drain to the read word bypasses
	for (genvar g = 0; g < sram_port_pkg::LANES; g++) begin : g_lane
		logic [sram_port_pkg::BYTE_W:0] mem [sram_port_pkg::MEM_WORDS];
		logic [sram_port_pkg::BYTE_W:0] wr_word;
		logic [sram_port_pkg::BYTE_W:0] rd_q;
		logic lane_wr;

		assign wr_word = {drain_entry.par[g],
			drain_entry.data[g*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W]};
		assign lane_wr = drain_fire && drain_entry.lanes[g];

		always_ff @(posedge core_clk) begin
			if (lane_wr) begin
				mem[drain_entry.addr] <= wr_word;
			end
			if (lane_wr && drain_entry.addr == rd_addr) begin
				rd_q <= wr_word;
			end else begin
				rd_q <= mem[rd_addr];
			end
		end

		assign data_io_out[g*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W] =
			rd_q[sram_port_pkg::BYTE_W-1:0];
		assign parity_io_out[g] = rd_q[sram_port_pkg::BYTE_W];
	end

	// Pins driven only in a live read, past its first cycle if begun from idle; a decoded
	// write releases them at once, before its phase flag is registered
	always_comb begin
		drive = state == sram_port_pkg::ST_ACTIVE && !first_read
			&& !wphase && !push && !s.oe_n;
		data_io_oe_n = !drive;
		parity_io_oe_n = !drive;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	desel_decode_a: assert property (
		s.sleep == 1'b0 && state != sram_port_pkg::ST_SLEEP && start_acc
			&& !sel_ok |=> state == sram_port_pkg::ST_IDLE && data_io_oe_n)
		else $error("unselected strobe did not deselect");
	cs_ignored_a: assert property (
		state == sram_port_pkg::ST_ACTIVE && !s.sleep && !start_acc
			|=> state == sram_port_pkg::ST_ACTIVE && $stable(addr_reg))
		else $error("burst cycle reacted to chip selects");
	proc_addr_strobe_n_gate_a: assert property (
		state == sram_port_pkg::ST_IDLE && !s.sleep && !s.proc_addr_strobe_n_n
			&& s.cs_low_a && s.ctrl_addr_strobe_n_n
			|=> state == sram_port_pkg::ST_IDLE && $stable(addr_reg))
		else $error("processor strobe taken with low_a high");
	addr_load_a: assert property (
		!s.sleep && state != sram_port_pkg::ST_SLEEP && start_acc && sel_ok
			|=> addr_reg == $past(s.addr) && start == $past(s.addr[1:0])
			&& cnt == sram_port_pkg::BURST_CNT_RST)
		else $error("address or burst counter not loaded");
	proc_addr_strobe_n_prio_a: assert property (
		!s.sleep && state != sram_port_pkg::ST_SLEEP && strobe_p && sel_ok
			&& !s.ctrl_addr_strobe_n_n |=> !wphase)
		else $error("controller strobe acted beside processor strobe");
	burst_step_a: assert property (
		state == sram_port_pkg::ST_ACTIVE && !s.sleep && !start_acc
			&& !s.adv_n |=> cnt == BW'($past(cnt) + 1'b1))
		else $error("advance did not step the burst");
	oe_follow_a: assert property (
		state == sram_port_pkg::ST_ACTIVE && !first_read && !wphase && !push
			|-> data_io_oe_n == s.oe_n)
		else $error("pin drive does not follow output enable");
	first_mask_a: assert property (
		state == sram_port_pkg::ST_IDLE && !s.sleep && start_acc && sel_ok
			&& next_wphase == 1'b0 |=> data_io_oe_n ##1
			(data_io_oe_n == s.oe_n || state != sram_port_pkg::ST_ACTIVE
			|| wphase || push || first_read))
		else $error("first read cycle drove the pins");
	write_tri_a: assert property (
		wphase || push || state != sram_port_pkg::ST_ACTIVE
			|-> data_io_oe_n && parity_io_oe_n)
		else $error("pins driven in write or deselect");
	global_wr_a: assert property (
		state == sram_port_pkg::ST_ACTIVE && !s.sleep && !start_acc
			&& !s.gw_n |-> push && push_entry.lanes == sram_port_pkg::ALL_LANES
			##1 wphase)
		else $error("global write missed a lane");
	order_seq_a: assert property (
		state == sram_port_pkg::ST_ACTIVE |-> cur_addr[1:0] == (mode_linear
			? BW'(start + cnt) : (start ^ cnt)))
		else $error("burst address out of sequence");
endmodule // sync_burst_sram_port
`default_nettype wire

// file: verification/sram_host.sv
`default_nettype none
// Host side of the memory bus: drives pins, resolves the shared lines
module sram_host (
	input wire logic core_clk,
	output logic chip_select_low_a,
	output logic chip_select_high,
	output logic chip_select_low_b,
	output logic proc_addr_strobe_n,
	output logic ctrl_addr_strobe_n,
	output logic burst_advance_n,
	output logic byte_write_enable_n,
	output logic [3:0] byte_select_n,
	output logic global_write_n,
	output logic output_enable_n,
	output logic sleep_req,
	output logic burst_order,
	output logic [17:0] addr,
	output logic [31:0] data_io_in,
	output logic [3:0] parity_io_in,
	input wire logic [31:0] data_io_out,
	input wire logic data_io_oe_n,
	input wire logic [3:0] parity_io_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [35:0] wr_word;
	logic [35:0] last;
	logic host_drv;

	// Idle bus at time zero
	initial begin
		{chip_select_low_a, chip_select_high, chip_select_low_b} = 3'h2;
		{proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
		{global_write_n, byte_write_enable_n, byte_select_n} = 6'h3F;
		output_enable_n = 1'b1;
		sleep_req = 1'b0;
		burst_order = 1'b0;
		addr = 18'h00000;
		wr_word = 36'h000000000;
		host_drv = 1'b0;
	end

	// Released lines drift, so a stale level never passes as data
	always_ff @(posedge core_clk) last <= {parity_io_in, data_io_in};
	always_comb begin
		if (!data_io_oe_n) begin
			{parity_io_in, data_io_in} = {parity_io_out, data_io_out};
		end else if (host_drv) begin
			{parity_io_in, data_io_in} = wr_word;
		end else begin
			{parity_io_in, data_io_in} = ~last;
		end
	end

	// One bus cycle, pins changed just after the falling edge
	task automatic cyc(input logic [2:0] sel, input logic [2:0] str,
		input logic [5:0] wen, input logic [17:0] a, input logic [35:0] d);
		@(negedge core_clk);
		{chip_select_low_a, chip_select_high, chip_select_low_b} = sel;
		{proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = str;
		{global_write_n, byte_write_enable_n, byte_select_n} = wen;
		addr = a;
		wr_word = d;
		host_drv = (wen[5:4] != 2'h3);
	endtask
endmodule // sram_host
`default_nettype wire

// file: verification/sync_burst_sram_port_test.sv
`default_nettype none
module sync_burst_sram_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] sel_ok = 3'h2;
	logic core_clk, sys_rst, chip_select_low_a, chip_select_high;
	logic chip_select_low_b, proc_addr_strobe_n, ctrl_addr_strobe_n;
	logic burst_advance_n, byte_write_enable_n, global_write_n;
	logic output_enable_n, sleep_req, burst_order, data_io_oe_n;
	logic parity_io_oe_n, write_ready;
	logic [3:0] byte_select_n, parity_io_in, parity_io_out;
	logic [17:0] addr;
	logic [31:0] data_io_in, data_io_out;
	int mismatches, total_checks;
	logic alt_oe_n;
	logic [1:0] oe_pins;

	sync_burst_sram_port dut (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.chip_select_low_a(chip_select_low_a),
		.chip_select_high(chip_select_high),
		.chip_select_low_b(chip_select_low_b),
		.proc_addr_strobe_n(proc_addr_strobe_n),
		.ctrl_addr_strobe_n(ctrl_addr_strobe_n),
		.burst_advance_n(burst_advance_n),
		.byte_write_enable_n(byte_write_enable_n),
		.byte_select_n(byte_select_n),
		.global_write_n(global_write_n),
		.output_enable_n(output_enable_n),
		.sleep_req(sleep_req),
		.burst_order(burst_order),
		.addr(addr),
		.data_io_in(data_io_in),
		.data_io_out(data_io_out),
		.data_io_oe_n(data_io_oe_n),
		.parity_io_in(parity_io_in),
		.parity_io_out(parity_io_out),
		.parity_io_oe_n(parity_io_oe_n),
		.write_ready(write_ready)
	);

	// Two-select variant on the same pins; only its pin drive is watched
	sync_burst_sram_port #(
		.HAS_LOW_B(1'b0)
	) dut_two_sel (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.chip_select_low_a(chip_select_low_a),
		.chip_select_high(chip_select_high),
		.chip_select_low_b(chip_select_low_b),
		.proc_addr_strobe_n(proc_addr_strobe_n),
		.ctrl_addr_strobe_n(ctrl_addr_strobe_n),
		.burst_advance_n(burst_advance_n),
		.byte_write_enable_n(byte_write_enable_n),
		.byte_select_n(byte_select_n),
		.global_write_n(global_write_n),
		.output_enable_n(output_enable_n),
		.sleep_req(sleep_req),
		.burst_order(burst_order),
		.addr(addr),
		.data_io_in(data_io_in),
		.data_io_out(),
		.data_io_oe_n(alt_oe_n),
		.parity_io_in(parity_io_in),
		.parity_io_out(),
		.parity_io_oe_n(),
		.write_ready()
	);

	sram_host host (
		.core_clk(core_clk),
		.chip_select_low_a(chip_select_low_a),
		.chip_select_high(chip_select_high),
		.chip_select_low_b(chip_select_low_b),
		.proc_addr_strobe_n(proc_addr_strobe_n),
		.ctrl_addr_strobe_n(ctrl_addr_strobe_n),
		.burst_advance_n(burst_advance_n),
		.byte_write_enable_n(byte_write_enable_n),
		.byte_select_n(byte_select_n),
		.global_write_n(global_write_n),
		.output_enable_n(output_enable_n),
		.sleep_req(sleep_req),
		.burst_order(burst_order),
		.addr(addr),
		.data_io_in(data_io_in),
		.parity_io_in(parity_io_in),
		.data_io_out(data_io_out),
		.data_io_oe_n(data_io_oe_n),
		.parity_io_out(parity_io_out)
	);

	// Both release flags together, so parity drive is judged as well
	assign oe_pins = {parity_io_oe_n, data_io_oe_n};

	// Free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) host.cyc(sel_ok, 3'h7, 6'h3F, 18'h00000, 36'h0);
	endtask

	// Controller-strobe write, one cycle
	task automatic wr(input logic [17:0] a, input logic [5:0] w,
		input logic [35:0] d);
		host.cyc(sel_ok, 3'h5, w, a, d);
		idle(1);
	endtask

	// Controller-strobe read; pins lag two edges, so look three later
	task automatic rd(input logic [17:0] a, input logic [35:0] exp);
		host.cyc(sel_ok, 3'h5, 6'h3F, a, 36'h0);
		idle(3);
		check({parity_io_out, data_io_out}, exp);
	endtask

	task automatic reset_dut(input logic order);
		@(negedge core_clk);
		sys_rst = 1'b1;
		host.burst_order = order;
		repeat (5) @(negedge core_clk);
		sys_rst = 1'b0;
		idle(2);
	endtask

	// Global, byte-qualified and unqualified writes to one word
	task automatic lane_writes();
		wr(18'h00010, 6'h1F, 36'hF01234567);
		wr(18'h00010, 6'h2A, 36'h089ABCDEF);
		wr(18'h00010, 6'h30, 36'h0FFFFFFFF);
		rd(18'h00010, 36'hA01AB45EF);
	endtask

	// Both strobes low: first-cycle writes dropped, next writes lane 0
	task automatic strobe_priority();
		wr(18'h00030, 6'h1F, 36'h000000000);
		host.cyc(sel_ok, 3'h1, 6'h1F, 18'h00030, 36'hFFFFFFFFF);
		host.cyc(sel_ok, 3'h7, 6'h2E, 18'h3FFFF, 36'h1000000C3);
		idle(1);
		rd(18'h00030, 36'h1000000C3);
	endtask

	// Selection, release of pins on write and sleep, output enable low
	task automatic no_select();
		logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
		host.output_enable_n = 1'b0;
		foreach (bad[k]) begin
			host.cyc(3'h0, 3'h5, 6'h3F, 18'h00000, 36'h0);
			host.cyc(bad[k], 3'h3, 6'h3F, 18'h00010, 36'h0);
			idle(4);
			check(36'(data_io_oe_n), 36'h1);
			check(36'(alt_oe_n), k == 2 ? 36'h0 : 36'h1);
		end
		host.cyc(sel_ok, 3'h3, 6'h3F, 18'h00010, 36'h0);
		repeat (4) host.cyc(3'h0, 3'h7, 6'h3F, 18'h00000, 36'h0);
		check(36'(data_io_oe_n), 36'h0);
		// Processor strobe with low_a high must leave the burst running
		host.cyc(3'h6, 3'h3, 6'h3F, 18'h00000, 36'h0);
		idle(3);
		check(36'(data_io_oe_n), 36'h0);
		// Output enable goes high so the port lets go of the bus before the host's write data, to avoid a clash
		host.output_enable_n = 1'b1;
		idle(1);
		host.cyc(sel_ok, 3'h7, 6'h1F, 18'h00000, 36'h7A5A5A5A5);
		host.output_enable_n = 1'b0;
		idle(2);
		check(36'(oe_pins), 36'h3);
		idle(1);
		check(36'(oe_pins), 36'h3);
		rd(18'h00010, 36'h7A5A5A5A5);
		host.sleep_req = 1'b1;
		idle(4);
		check(36'(data_io_oe_n), 36'h1);
		host.sleep_req = 1'b0;
		idle(3);
		rd(18'h00010, 36'h7A5A5A5A5);
		host.output_enable_n = 1'b1;
	endtask

	// Four-beat burst from a deselected start, checked beat by beat
	task automatic burst(input logic order, input logic [1:0] start);
		logic [1:0] seq;
		reset_dut(order);
		for (int i = 0; i < 4; i++)
			wr(18'h00020 | 18'(i), 6'h1F, 36'h512345600 | 36'(i));
		host.output_enable_n = 1'b0;
		host.cyc(3'h0, 3'h5, 6'h3F, 18'h00000, 36'h0);
		for (int i = 0; i < 7; i++) begin
			host.cyc(sel_ok, i == 0 ? 3'h3 : (i < 4 ? 3'h6 : 3'h7), 6'h3F,
				18'h00020 | 18'(start), 36'h0);
			seq = order ? start ^ 2'(i - 3) : start + 2'(i - 3);
			if (i == 3) check(36'(oe_pins), 36'h3);
			if (i == 4) check(36'(oe_pins), 36'h0);
			if (i >= 3) check({parity_io_out, data_io_out},
				36'h512345600 | 36'(seq));
		end
		host.output_enable_n = 1'b1;
	endtask

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		mismatches = 0;
		total_checks = 0;
		reset_dut(1'b0);
		check(36'(write_ready), 36'h1);
		lane_writes();
		strobe_priority();
		no_select();
		burst(1'b0, 2'h1);
		burst(1'b1, 2'h1);
		burst(1'b1, 2'h2);
		summarize();
	end

	// Guard against a hang anywhere in the sequence
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		summarize();
	end
endmodule // sync_burst_sram_port_test
`default_nettype wire
